// ==== src/phy_port_config_status_regs.sv ====
// per-port management registers: configuration, quick status, interrupt enable, interrupt status
// assumes: one management port, same clock; port state inputs asynchronous
//
// Decided for this implementation: strobed register access.
module phy_port_config_status_regs
  import port_regs_pkg::*;
#(
  parameter int NPORTS = `NUM_PORTS
)
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // management register port
  input  wire logic [2:0]             port_sel,
  input  wire mgmt_req_t              req,
  output logic      [15:0]            rdata,
  // per-port state and straps (asynchronous)
  input  wire port_state_t            state_in          [NPORTS],
  input  wire logic                   media_select_strap [NPORTS],
  input  wire logic                   pause_advert      [NPORTS],
  // per-port controls and interrupts
  output port_ctrl_t                  ctrl              [NPORTS],
  output logic                        port_irq          [NPORTS]
);

  // elaboration check: port select is three bits wide
  if (NPORTS < 1 || NPORTS > 8)
  begin : g_bad_nports
    $error("NPORTS must be 1 to 8");
  end

  // ==========================================================
  // helpers
  function automatic reg16_t wmask(input reg16_t old, input reg16_t nw, input reg16_t m);
    wmask = (old & ~m) | (nw & m);
  endfunction

  function automatic logic sel(input logic [2:0] p, input int i, input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] o);
    sel = (p == 3'(i)) && (a == o);
  endfunction

  // ==========================================================
  // strap capture sequencing
  // high for two edges after release: the strap synchroniser needs both to fill
  logic [1:0] strap_load_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      strap_load_q <= 2'b11;
    else
      strap_load_q <= {strap_load_q[0], 1'b0};
  end

  reg16_t rd_mux [NPORTS];
  logic   rd_hit [NPORTS];

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : gp
      // ======================================================
      // synchronisers
      port_state_t st_s1_q;
      port_state_t st_q;
      logic        strap_s1_q;
      logic        strap_q;
      logic        pause_s1_q;
      logic        pause_q;
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          st_s1_q    <= '0;
          st_q       <= '0;
          strap_s1_q <= 1'b0;
          strap_q    <= 1'b0;
          pause_s1_q <= 1'b0;
          pause_q    <= 1'b0;
        end
        else
        begin
          st_s1_q    <= state_in[g];
          st_q       <= st_s1_q;
          strap_s1_q <= media_select_strap[g];
          strap_q    <= strap_s1_q;
          pause_s1_q <= pause_advert[g];
          pause_q    <= pause_s1_q;
        end
      end

      // ======================================================
      // register decode
      wire wr_cfg = req.wr && sel(port_sel, g, req.addr, `OFS_PORT_CONFIG);
      wire wr_ie  = req.wr && sel(port_sel, g, req.addr, `OFS_INT_ENABLE);
      wire rd_is  = req.rd && sel(port_sel, g, req.addr, `OFS_INT_STATUS);

      // ======================================================
      // port configuration
      reg16_t cfg_q;
      reg16_t cfg_d;
      logic   strap_wait_q;
      assign cfg_d = wr_cfg ? req.wdata : cfg_q;
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          cfg_q        <= `CFG_RESET;
          strap_wait_q <= 1'b1;
        end
        else
        begin
          // strap settles through the synchroniser before loading
          strap_wait_q <= strap_load_q[1];
          if (strap_wait_q && !strap_load_q[1] && !wr_cfg)
            cfg_q <= wmask(cfg_q, {15'h0000, strap_q}, 16'h0001);
          else
            cfg_q <= cfg_d;
        end
      end

      // ======================================================
      // interrupt enable and change flags
      reg16_t ie_q;
      logic   spd_flag_q;
      logic   dup_flag_q;
      logic   lnk_flag_q;
      logic   an_prev_q;
      logic   an_evt_q;
      logic   irq_q;
      port_ctrl_t ctrl_q;
      port_state_t st_prev_q;
      wire e_spd = st_q.speed_100   != st_prev_q.speed_100;
      wire e_dup = st_q.full_duplex != st_prev_q.full_duplex;
      wire e_lnk = st_q.link_up     != st_prev_q.link_up;
      wire e_an  = st_q.an_complete && !an_prev_q;
      wire ev_any = (spd_flag_q && ie_q[`IE_SPEED_MASK])
                  | (dup_flag_q && ie_q[`IE_DUPLEX_MASK])
                  | (lnk_flag_q && ie_q[`IE_LINK_MASK])
                  | (an_evt_q   && ie_q[`IE_AN_MASK]);
      wire irq_d = ie_q[`IE_PORT_EN] && (ev_any || ie_q[`IE_FORCE_INT]);
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          ie_q       <= `IE_RESET;
          spd_flag_q <= 1'b0;
          dup_flag_q <= 1'b0;
          lnk_flag_q <= 1'b0;
          an_prev_q  <= 1'b0;
          an_evt_q   <= 1'b0;
          st_prev_q  <= '0;
          irq_q      <= 1'b0;
          ctrl_q     <= '0;
        end
        else
        begin
          if (wr_ie)
            ie_q <= {8'h00, req.wdata[7:0]};
          st_prev_q  <= st_q;
          an_prev_q  <= st_q.an_complete;
          // set wins over the read clear
          spd_flag_q <= e_spd | (spd_flag_q & ~rd_is);
          dup_flag_q <= e_dup | (dup_flag_q & ~rd_is);
          lnk_flag_q <= e_lnk | (lnk_flag_q & ~rd_is);
          an_evt_q   <= e_an  | (an_evt_q   & ~rd_is);
          irq_q      <= irq_d;
          ctrl_q.force_link_pass  <= cfg_d[`CFG_FORCE_LINK];
          ctrl_q.tx_disable       <= cfg_d[`CFG_TX_DISABLE];
          ctrl_q.scram_bypass     <= cfg_d[`CFG_SCRAM_BYPASS];
          ctrl_q.jabber_disable   <= cfg_d[`CFG_JABBER_DIS];
          ctrl_q.loopback_disable <= cfg_d[`CFG_LOOP_DIS];
          ctrl_q.fifo_8k          <= cfg_d[`CFG_FIFO_SIZE];
          ctrl_q.preamble_pass    <= cfg_d[`CFG_PREAMBLE];
          ctrl_q.fef_tx_enable    <= cfg_d[`CFG_FEF_EN];
          ctrl_q.alt_next_page    <= cfg_d[`CFG_ALT_NP];
          ctrl_q.fiber_mode       <= cfg_d[`CFG_FIBER];
        end
      end
      assign ctrl[g]     = ctrl_q;
      assign port_irq[g] = irq_q;

      // ======================================================
      // read selection
      reg16_t qs;
      reg16_t is_v;
      always_comb
      begin
        qs                = 16'h0000;
        qs[`QS_SPEED]     = st_q.speed_100;
        qs[`QS_TX_ACT]    = st_q.tx_active;
        qs[`QS_RX_ACT]    = st_q.rx_active;
        qs[`QS_COLL]      = st_q.collision;
        qs[`QS_LINK]      = st_q.link_up;
        qs[`QS_DUPLEX]    = st_q.full_duplex;
        qs[`QS_AN_MODE]   = st_q.an_mode;
        qs[`QS_AN_DONE]   = st_q.an_complete;
        qs[`QS_POLARITY]  = st_q.pol_reversed;
        qs[`QS_PAUSE]     = pause_q;
        qs[`QS_ERROR]     = st_q.remote_error;
        is_v                 = 16'h0000;
        is_v[`IS_AN_DONE]    = an_evt_q;
        is_v[`IS_SPEED_CHG]  = spd_flag_q;
        is_v[`IS_DUPLEX_CHG] = dup_flag_q;
        is_v[`IS_LINK_CHG]   = lnk_flag_q;
        is_v[`IS_INT_PEND]   = irq_q;
      end
      wire h_cfg = sel(port_sel, g, req.addr, `OFS_PORT_CONFIG);
      wire h_qs  = sel(port_sel, g, req.addr, `OFS_QUICK_STATUS);
      wire h_ie  = sel(port_sel, g, req.addr, `OFS_INT_ENABLE);
      wire h_is  = sel(port_sel, g, req.addr, `OFS_INT_STATUS);
      assign rd_hit[g] = h_cfg | h_qs | h_ie | h_is;
      assign rd_mux[g] = h_cfg ? cfg_q :
                         h_qs  ? qs    :
                         h_ie  ? ie_q  :
                         h_is  ? is_v  : 16'h0000;
    end
  endgenerate

  // ==========================================================
  // read data, one cycle after strobe; unmapped and 9/10/15 read zero
  reg16_t rd_sel;
  always_comb
  begin
    rd_sel = 16'h0000;
    for (int i = 0; i < NPORTS; i++)
      if (rd_hit[i])
        rd_sel = rd_mux[i];
  end

  logic [15:0] rdata_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 16'h0000;
    else if (req.rd)
      rdata_q <= rd_sel;
    else
      rdata_q <= 16'h0000;
  end
  assign rdata = rdata_q;

endmodule

// ==== pkg/port_regs_cfg.svh ====
// register map, field positions, reset values for the per-port register bank
// assumes: included by the package and the testbench files
`ifndef PORT_REGS_CFG_SVH
`define PORT_REGS_CFG_SVH

`define ADDR_W              5
`define OFS_AN_ADVERT       5'h04
`define OFS_PORT_CONFIG     5'h10
`define OFS_QUICK_STATUS    5'h11
`define OFS_INT_ENABLE      5'h12
`define OFS_INT_STATUS      5'h13
`define OFS_UNIMPL_A        5'h09
`define OFS_UNIMPL_B        5'h0A
`define OFS_UNIMPL_C        5'h0F

`define CFG_FORCE_LINK      14
`define CFG_TX_DISABLE      13
`define CFG_SCRAM_BYPASS    12
`define CFG_JABBER_DIS      10
`define CFG_LOOP_DIS        8
`define CFG_FIFO_SIZE       6
`define CFG_PREAMBLE        5
`define CFG_FEF_EN          2
`define CFG_ALT_NP          1
`define CFG_FIBER           0
`define CFG_RESET           16'h0104

`define QS_SPEED            14
`define QS_TX_ACT           13
`define QS_RX_ACT           12
`define QS_COLL             11
`define QS_LINK             10
`define QS_DUPLEX           9
`define QS_AN_MODE          8
`define QS_AN_DONE          7
`define QS_POLARITY         5
`define QS_PAUSE            4
`define QS_ERROR            3

`define IE_AN_MASK          7
`define IE_SPEED_MASK       6
`define IE_DUPLEX_MASK      5
`define IE_LINK_MASK        4
`define IE_PORT_EN          1
`define IE_FORCE_INT        0
`define IE_RESET            16'h0000

`define IS_AN_DONE          7
`define IS_SPEED_CHG        6
`define IS_DUPLEX_CHG       5
`define IS_LINK_CHG         4
`define IS_INT_PEND         2

`define ADV_PAUSE           10
`define NUM_PORTS           8
`endif

// ==== pkg/port_regs_pkg.sv ====
// types shared by the per-port register bank
// assumes: cfg header carries all numbers
`include "port_regs_cfg.svh"
package port_regs_pkg;

  typedef logic [15:0] reg16_t;

  // live per-port state from the data path
  typedef struct packed
  {
    logic speed_100;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic link_up;
    logic full_duplex;
    logic an_mode;
    logic an_complete;
    logic pol_reversed;
    logic remote_error;
  } port_state_t;

  // control levels driven into the data path
  typedef struct packed
  {
    logic force_link_pass;
    logic tx_disable;
    logic scram_bypass;
    logic jabber_disable;
    logic loopback_disable;
    logic fifo_8k;
    logic preamble_pass;
    logic fef_tx_enable;
    logic alt_next_page;
    logic fiber_mode;
  } port_ctrl_t;

  typedef struct packed
  {
    logic [`ADDR_W-1:0] addr;
    logic [15:0]        wdata;
    logic               wr;
    logic               rd;
  } mgmt_req_t;

endpackage

// ==== tb/port_regs_props.sv ====
// checker for the register bank, watching port 0
// assumes: bound to the top module, one clock domain
`include "port_regs_cfg.svh"
module port_regs_props
  import port_regs_pkg::*;
#(
  parameter int NPORTS = 8
)
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // register port
  input wire logic [2:0]  port_sel,
  input wire mgmt_req_t   req,
  input wire logic [15:0] rdata,
  // port side
  input wire port_state_t state_in [NPORTS],
  input wire logic        media_select_strap [NPORTS],
  input wire logic        pause_advert [NPORTS],
  input wire port_ctrl_t  ctrl [NPORTS],
  input wire logic        port_irq [NPORTS]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ====
  // port 0 mirrors
  wire        p0 = port_sel == 3'h0;
  wire        wr_cfg = req.wr && p0 && req.addr == `OFS_PORT_CONFIG;
  wire        wr_ie = req.wr && p0 && req.addr == `OFS_INT_ENABLE;
  wire [10:0] now = {pause_advert[0], state_in[0]};
  logic [15:0] wd1_q, wd2_q, cfg_q, ie_q;
  logic [10:0] prev_q;
  logic [2:0]  cnt_q;
  wire [9:0]   pk = {wd2_q[14:12], wd2_q[10], wd2_q[8], wd2_q[6:5], wd2_q[2:0]};
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      {wd1_q, wd2_q, ie_q, prev_q, cnt_q} <= '0;
      cfg_q <= `CFG_RESET;
    end
    else
    begin
      wd1_q <= req.wdata;
      wd2_q <= wd1_q;
      if (wr_cfg) cfg_q <= req.wdata;
      if (wr_ie) ie_q <= {8'h00, req.wdata[7:0]};
      prev_q <= now;
      cnt_q <= (now != prev_q) ? 3'h0 : (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    end
  // ====
  // properties
  rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  cfg_ctrl_a: assert property (wr_cfg ##1 !wr_cfg |-> ##1 ctrl[0] == pk)
    else $error("controls differ from written config");
  cfg_read_a: assert property (req.rd && p0 && req.addr == `OFS_PORT_CONFIG |->
    ##1 (rdata & 16'hFFFE) == ($past(cfg_q) & 16'hFFFE))
    else $error("config readback wrong");
  ie_read_a: assert property (req.rd && p0 && req.addr == `OFS_INT_ENABLE |->
    ##1 rdata == $past(ie_q))
    else $error("interrupt enable readback wrong");
  unimpl_zero_a: assert property (req.rd && (req.addr == `OFS_UNIMPL_A ||
    req.addr == `OFS_UNIMPL_B || req.addr == `OFS_UNIMPL_C) |-> ##1 rdata == 16'h0000)
    else $error("unimplemented address read nonzero");
  irq_gate_a: assert property (!ie_q[1] |-> ##1 !port_irq[0])
    else $error("interrupt while port disabled");
  irq_force_a: assert property (ie_q[1] && ie_q[0] |-> ##1 port_irq[0])
    else $error("forced interrupt missing");
  qs_live_a: assert property (req.rd && p0 && req.addr == `OFS_QUICK_STATUS && cnt_q >= 3'h6
    |-> ##1 rdata == {1'b0, prev_q[9:2], 1'b0, prev_q[1], prev_q[10], prev_q[0], 3'h0})
    else $error("quick status differs from live state");
endmodule

// ==== tb/mgmt_master.sv ====
// station management side: register port master
// assumes: one read or write at a time, from a single caller
`include "port_regs_cfg.svh"
module mgmt_master
  import port_regs_pkg::*;
(
  // clock
  input wire logic        mclk,
  // register port
  output logic [2:0]      port_sel,
  output mgmt_req_t       req,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    port_sel = 3'h0;
    req = '0;
  end
  task automatic wr(input logic [2:0] p, input logic [4:0] a, input reg16_t d);
    @(posedge mclk);
    port_sel <= p;
    req.addr <= a;
    req.wdata <= (a == `OFS_PORT_CONFIG) ? (d & 16'hFFE7) : d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [4:0] a, output reg16_t q);
    @(posedge mclk);
    port_sel <= p;
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    q = rdata;
  endtask
endmodule

// ==== tb/phy_port_config_status_regs_tb.sv ====
// testbench for the per-port register bank
// assumes: design, master and checker compiled before it
`include "port_regs_cfg.svh"
module phy_port_config_status_regs_tb;
  import port_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPORTS = 8;
  typedef struct {logic [2:0] p; logic [4:0] a; reg16_t d; reg16_t e;} row_t;
  typedef struct {reg16_t ie; logic [9:0] tg; logic irq; int fb;} irow_t;
  logic        mclk, nrst;
  logic [2:0]  port_sel;
  mgmt_req_t   req;
  logic [15:0] rdata;
  port_state_t st [NPORTS];
  logic        strap [NPORTS];
  logic        pause [NPORTS];
  port_ctrl_t  ctrl [NPORTS];
  logic        port_irq [NPORTS];
  int          n_fail, checks_done;
  reg16_t      q;
  logic [9:0]  pat;
  row_t rows [7] = '{'{3'h0, 5'h10, 16'hFFFF, 16'hFFE7}, '{3'h2, 5'h10, 16'h5125, 16'h5125},
    '{3'h3, 5'h10, 16'h2A42, 16'h2A42}, '{3'h0, 5'h12, 16'hFFFF, 16'h00FF},
    '{3'h3, 5'h11, 16'hFFFF, 16'h0000}, '{3'h4, 5'h09, 16'hFFFF, 16'h0000},
    '{3'h4, 5'h0F, 16'hFFFF, 16'h0000}};
  irow_t irows [7] = '{'{16'h0012, 10'h020, 1'b1, 4}, '{16'h0022, 10'h010, 1'b1, 5},
    '{16'h0042, 10'h200, 1'b1, 6}, '{16'h0082, 10'h004, 1'b1, 7},
    '{16'h0002, 10'h020, 1'b0, 4}, '{16'h00F0, 10'h020, 1'b0, 4},
    '{16'h0003, 10'h000, 1'b1, 2}};
  phy_port_config_status_regs #(.NPORTS(NPORTS)) dut (.mclk(mclk), .nrst(nrst),
    .port_sel(port_sel), .req(req), .rdata(rdata), .state_in(st), .media_select_strap(strap),
    .pause_advert(pause), .ctrl(ctrl), .port_irq(port_irq));
  mgmt_master mm (.mclk(mclk), .port_sel(port_sel), .req(req), .rdata(rdata));
  // ====
  // helpers
  function automatic logic [9:0] pk(input reg16_t w);
    return {w[14:12], w[10], w[8], w[6:5], w[2:0]};
  endfunction
  task chk_word(input reg16_t got, input reg16_t exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask
  task close_out;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task do_reset;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // ====
  // clock, watchdog
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out;
  end
  // ====
  // main sequence
  initial
  begin
    nrst = 1'b0;
    for (int p = 0; p < NPORTS; p++)
    begin
      st[p] = '0;
      strap[p] = p[0];
      pause[p] = 1'b0;
    end
    do_reset;
    foreach (rows[i])
    begin
      mm.wr(rows[i].p, rows[i].a, rows[i].d);
      mm.rd(rows[i].p, rows[i].a, q);
      chk_word(q, rows[i].e);
      if (rows[i].a == `OFS_PORT_CONFIG)
        chk_word({6'h0, ctrl[rows[i].p]}, {6'h0, pk(rows[i].e)});
    end
    mm.rd(3'h1, `OFS_PORT_CONFIG, q);
    chk_word(q, 16'h0105);
    $display("table test done");
    foreach (irows[i])
    begin
      mm.wr(3'h0, `OFS_INT_ENABLE, irows[i].ie);
      st[0] <= st[0] ^ irows[i].tg;
      repeat (8) @(posedge mclk);
      chk_bit(port_irq[0], irows[i].irq);
      mm.rd(3'h0, `OFS_INT_STATUS, q);
      chk_bit(q[irows[i].fb], 1'b1);
      repeat (3) @(posedge mclk);
      if (irows[i].tg != 0)
        chk_bit(port_irq[0], 1'b0);
    end
    mm.wr(3'h0, `OFS_INT_ENABLE, 16'h0000);
    $display("interrupt test done");
    for (int k = 0; k < 2; k++)
    begin
      pat = k ? 10'h155 : 10'h3FF;
      st[0] <= pat;
      pause[0] <= ~k[0];
      repeat (8) @(posedge mclk);
      mm.rd(3'h0, `OFS_QUICK_STATUS, q);
      chk_word(q, {1'b0, pat[9:2], 1'b0, pat[1], ~k[0], pat[0], 3'h0});
    end
    $display("status test done");
    do_reset;
    for (int p = 0; p < NPORTS; p++)
    begin
      mm.rd(p[2:0], `OFS_PORT_CONFIG, q);
      chk_word(q, 16'h0104 | {15'h0, p[0]});
      chk_word({6'h0, ctrl[p]}, {6'h0, pk(16'h0104 | {15'h0, p[0]})});
      mm.rd(p[2:0], `OFS_INT_ENABLE, q);
      chk_word(q, 16'h0000);
    end
    $display("reset test done");
    close_out;
  end
endmodule
bind phy_port_config_status_regs port_regs_props #(.NPORTS(NPORTS)) props (.mclk(mclk),
  .nrst(nrst), .port_sel(port_sel), .req(req), .rdata(rdata), .state_in(state_in),
  .media_select_strap(media_select_strap), .pause_advert(pause_advert), .ctrl(ctrl),
  .port_irq(port_irq));
